// file: logic/hcu_pkg.sv
// Shared constants and carrier types of the HCI UART with wake lines.
// Assumes a single 25 MHz system clock and an 8N1 asynchronous link.
package hcu_pkg;
    // ----------------------------------------
    // Clock and baud generator
    // ----------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam int OVERSAMPLE = 16;
    localparam int ACC_BITS = 16;
    localparam longint RATE_MIN_BPS = 115200;
    localparam longint RATE_MID_BPS = 921600;
    localparam longint RATE_MAX_BPS = 1500000;
    localparam longint RATE_DEFAULT_BPS = 115200;
    // Phase increment per clock for a rate: rate * 16 * 2^16 / 25 MHz, rounded
    localparam logic [15:0] INCR_MIN =
        16'((RATE_MIN_BPS * OVERSAMPLE * 65536 + CLK_HZ / 2) / CLK_HZ);
    localparam logic [15:0] INCR_MID =
        16'((RATE_MID_BPS * OVERSAMPLE * 65536 + CLK_HZ / 2) / CLK_HZ);
    localparam logic [15:0] INCR_MAX =
        16'((RATE_MAX_BPS * OVERSAMPLE * 65536 + CLK_HZ / 2) / CLK_HZ);
    localparam logic [15:0] INCR_DEFAULT =
        16'((RATE_DEFAULT_BPS * OVERSAMPLE * 65536 + CLK_HZ / 2) / CLK_HZ);

    // ----------------------------------------
    // Character framing
    // ----------------------------------------
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int FIFO_DEPTH = 1040;
    localparam int RTS_MARGIN = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RST_TXD = 1'b1;
    localparam logic RST_RTS_N = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } hcu_state_e;

    typedef struct packed {
        logic frame_err;
        logic [7:0] data;
    } hcu_rx_s;
endpackage : hcu_pkg

// file: logic/hcu_fifo.sv
// Synchronous valid/ready FIFO with flag outputs held in flip-flops.
// Assumes both sides run on the one system clock.
`timescale 1ns/10ps
`default_nettype none
module hcu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1040,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic push;
    logic pop;
    logic [CW-1:0] next_count;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rptr];

    always_comb begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + CW'(1);
        end else if (pop & ~push) begin
            next_count = count - CW'(1);
        end
    end

    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == LAST) ? '0 : wptr + AW'(1);
            end
            if (pop) begin
                rptr <= (rptr == LAST) ? '0 : rptr + AW'(1);
            end
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

    property p_fifo_bound;
        @(posedge clk) disable iff (rst)
        (count == CW'(DEPTH)) |-> !in_ready;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO full but still ready");
endmodule : hcu_fifo
`default_nettype wire

// file: logic/hcu_uart.sv
// HCI UART: 8N1 link with RTS/CTS, NCO baud generator and wake lines.
// Assumes the HCI command layer drives the baud and wake controls.
//
// Overview of operation
// - Link uses receive, transmit, RTS and CTS wires for hardware flow control.
// - Baud generator programmable from 115200 bps up to 1.5 Mbps.
// - Typical rates 115200, 921600, 1500000 plus intermediate rates in between.
// - Host command changes baud rate while traffic continues; generator switches.
// - Reception tolerates combined device and host baud error within five percent.
// - Separate 1040-byte receive and transmit FIFOs buffer the data.
// - After reset the link runs H4 framing at 115.2 kbaud.
// - One UART serves factory programming and normal HCI operation.
// - In HCI mode host drives device wake input, which may wake device.
// - Device drives host wake output when it needs host service.
// - Both wake lines stay inactive until enabled by host command.
`timescale 1ns/10ps
`default_nettype none
module hcu_uart
    import hcu_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int RTS_LEVEL = FIFO_DEPTH - RTS_MARGIN
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic UART_RXD,
    output logic UART_TXD,
    output logic UART_RTS_N,
    input wire logic UART_CTS_N,
    input wire logic DEVICE_WAKE_IN,
    output logic HOST_WAKE,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output hcu_rx_s RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic RX_OVERRUN,
    input wire logic [15:0] BAUD_INCR,
    input wire logic BAUD_LOAD,
    output logic BAUD_REJECT,
    input wire logic FACTORY_MODE,
    input wire logic WAKE_ENABLE,
    input wire logic HOST_WAKE_REQ,
    output logic DEVICE_WAKE
);
    localparam int CW = $clog2(DEPTH + 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_lvl;
    logic rx_lvl;
    logic cts_off;
    logic wake_lvl;

    // A level moves only once the second and third stages agree
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1 <= 3'h3;
            pin_s2 <= 3'h3;
            pin_s3 <= 3'h3;
            pin_lvl <= 3'h3;
        end else begin
            pin_s1 <= {DEVICE_WAKE_IN, UART_CTS_N, UART_RXD};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
        end
    end
    assign rx_lvl = pin_lvl[0];
    assign cts_off = pin_lvl[1];
    assign wake_lvl = pin_lvl[2];

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------
    logic [15:0] incr;
    logic [ACC_BITS-1:0] acc;
    logic tick;
    logic [ACC_BITS:0] next_acc;

    function automatic logic incr_ok(input logic [15:0] v);
        return (v >= INCR_MIN) && (v <= INCR_MAX);
    endfunction : incr_ok

    // Out-of-range requests are refused so the rate never leaves the range
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            incr <= INCR_DEFAULT;
            BAUD_REJECT <= 1'b0;
        end else begin
            BAUD_REJECT <= BAUD_LOAD & ~incr_ok(BAUD_INCR);
            if (BAUD_LOAD && incr_ok(BAUD_INCR)) begin
                incr <= BAUD_INCR;
            end
        end
    end

    // Fractional accumulator keeps the rate error far below the 5 % budget
    assign next_acc = {1'b0, acc} + {1'b0, incr};
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_acc[ACC_BITS-1:0];
            tick <= next_acc[ACC_BITS];
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    logic [7:0] txf_data;
    logic txf_valid;
    logic txf_pop;
    hcu_state_e tx_st;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;

    hcu_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_data(TX_DATA),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .out_data(txf_data),
        .out_valid(txf_valid),
        .out_ready(txf_pop),
        .count()
    );

    assign txf_pop = (tx_st == ST_IDLE) & tick & txf_valid & ~cts_off;

    // CTS is checked only between characters, never mid-frame
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tx_st <= ST_IDLE;
            tx_tick <= '0;
            tx_bit <= '0;
            tx_shift <= '0;
            UART_TXD <= RST_TXD;
        end else if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            case (tx_st)
                ST_IDLE: begin
                    tx_tick <= '0;
                    if (txf_valid && !cts_off) begin
                        tx_st <= ST_START;
                        tx_shift <= txf_data;
                        UART_TXD <= 1'b0;
                    end
                end
                ST_START: begin
                    if (tx_tick == TICK_LAST) begin
                        tx_st <= ST_DATA;
                        tx_bit <= '0;
                        UART_TXD <= tx_shift[0];
                    end
                end
                ST_DATA: begin
                    if (tx_tick == TICK_LAST) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == BIT_LAST) begin
                            tx_st <= ST_STOP;
                            UART_TXD <= 1'b1;
                        end else begin
                            UART_TXD <= tx_shift[1];
                        end
                    end
                end
                ST_STOP: begin
                    if (tx_tick == TICK_LAST) begin
                        tx_st <= ST_IDLE;
                    end
                end
                default: begin
                    tx_st <= ST_IDLE;
                    UART_TXD <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    hcu_state_e rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    hcu_rx_s rx_word;
    logic rx_push;
    logic rxf_ready;
    logic [CW-1:0] rx_count;
    logic rx_armed;

    // Start bit is confirmed at its middle; data sampled mid-bit for skew margin
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_st <= ST_IDLE;
            rx_tick <= '0;
            rx_bit <= '0;
            rx_shift <= '0;
            rx_push <= 1'b0;
            rx_word <= '0;
            rx_armed <= 1'b1;
        end else begin
            rx_push <= 1'b0;
            if (tick) begin
                rx_tick <= rx_tick + 4'h1;
                case (rx_st)
                    ST_IDLE: begin
                        rx_tick <= '0;
                        if (rx_lvl) begin
                            rx_armed <= 1'b1;
                        end else if (rx_armed) begin
                            rx_st <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (rx_tick == TICK_MID) begin
                            rx_tick <= '0;
                            rx_bit <= '0;
                            rx_st <= rx_lvl ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (rx_tick == TICK_LAST) begin
                            rx_shift <= {rx_lvl, rx_shift[7:1]};
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == BIT_LAST) begin
                                rx_st <= ST_STOP;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (rx_tick == TICK_LAST) begin
                            // Low stop bit: wait for an idle line, else its tail reads as a start
                            rx_armed <= rx_lvl;
                            rx_word.frame_err <= ~rx_lvl;
                            rx_word.data <= rx_shift;
                            rx_push <= 1'b1;
                            rx_st <= ST_IDLE;
                        end
                    end
                    default: begin
                        rx_st <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    hcu_fifo #(.WIDTH($bits(hcu_rx_s)), .DEPTH(DEPTH)) u_rx_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_data(rx_word),
        .in_valid(rx_push),
        .in_ready(rxf_ready),
        .out_data(RX_DATA),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .count(rx_count)
    );

    // Margin leaves room for characters the host sends before it sees RTS
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            UART_RTS_N <= RST_RTS_N;
            RX_OVERRUN <= 1'b0;
        end else begin
            UART_RTS_N <= (rx_count >= CW'(RTS_LEVEL));
            RX_OVERRUN <= rx_push & ~rxf_ready;
        end
    end

    // ----------------------------------------
    // Wake lines
    // ----------------------------------------
    // Factory programming uses the same link but keeps both wake lines quiet
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HOST_WAKE <= 1'b0;
            DEVICE_WAKE <= 1'b0;
        end else begin
            HOST_WAKE <= WAKE_ENABLE & ~FACTORY_MODE & HOST_WAKE_REQ;
            DEVICE_WAKE <= WAKE_ENABLE & ~FACTORY_MODE & wake_lvl;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_reset_rate;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> (incr == INCR_DEFAULT);
    endproperty
    a_reset_rate: assert property (p_reset_rate) else $error("Rate after reset not default");

    property p_rate_range;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (incr >= INCR_MIN) && (incr <= INCR_MAX);
    endproperty
    a_rate_range: assert property (p_rate_range) else $error("Baud increment out of range");

    property p_rate_load;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (BAUD_LOAD && incr_ok(BAUD_INCR)) |=> (incr == $past(BAUD_INCR)) && !BAUD_REJECT;
    endproperty
    a_rate_load: assert property (p_rate_load) else $error("Baud change not taken");

    property p_cts_hold;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (tx_st == ST_IDLE && cts_off) |=> (tx_st == ST_IDLE);
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("Character started while CTS off");

    property p_tx_frame;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        ((tx_st == ST_START) |-> !UART_TXD) and ((tx_st == ST_STOP || tx_st == ST_IDLE) |-> UART_TXD);
    endproperty
    a_tx_frame: assert property (p_tx_frame) else $error("Transmit line level wrong for state");

    property p_rts_full;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (rx_count >= CW'(RTS_LEVEL)) |=> UART_RTS_N;
    endproperty
    a_rts_full: assert property (p_rts_full) else $error("RTS not dropped near full");

    property p_wake_off;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !WAKE_ENABLE |=> !HOST_WAKE && !DEVICE_WAKE;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("Wake line active while disabled");

    property p_host_wake;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (WAKE_ENABLE && HOST_WAKE_REQ && !FACTORY_MODE) |=> HOST_WAKE;
    endproperty
    a_host_wake: assert property (p_host_wake) else $error("Host wake not raised");

    property p_device_wake_in;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (WAKE_ENABLE && !FACTORY_MODE && wake_lvl) |=> DEVICE_WAKE;
    endproperty
    a_device_wake_in: assert property (p_device_wake_in) else $error("Device wake not followed");
endmodule : hcu_uart
`default_nettype wire

// file: tb/hcu_host_model.sv
// Host side partner: sends and collects 8N1 characters on the link.
// Assumes the bench sets bit_clks to the bit time in system clocks.
`timescale 1ns/10ps
`default_nettype none
module hcu_host_model (
    input wire logic clk,
    output logic rxd,
    input wire logic txd,
    input wire logic rts_n,
    output logic cts_n
);
    // ----------------------------------------
    // Host transmitter and receiver
    // ----------------------------------------
    int bit_clks = 217;
    int n_sent = 0;
    logic ignore_rts = 1'b0;
    logic [8:0] got[$];
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        while (rts_n !== 1'b0 && !ignore_rts) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk) rxd <= fr[i];
            repeat (bit_clks - 1) @(posedge clk);
        end
        @(posedge clk) rxd <= 1'b1;
        n_sent++;
    endtask : send
    // Samples mid-bit, so a rounded bit time only eats into the margin
    initial begin : rx_proc
        logic [7:0] v;
        forever begin
            @(negedge txd);
            repeat (bit_clks / 2) @(posedge clk);
            for (int j = 0; j < 8; j++) begin
                repeat (bit_clks) @(posedge clk);
                v[j] = txd;
            end
            repeat (bit_clks) @(posedge clk);
            got.push_back({~txd, v});
        end
    end
endmodule : hcu_host_model
`default_nettype wire

// file: tb/hcu_uart_tb_top.sv
// Self-checking bench of the HCI UART with a host partner model.
// Assumes the design is built with DEPTH 8 and RTS_LEVEL 4.
`timescale 1ns/10ps
`default_nettype none
module hcu_uart_tb_top import hcu_pkg::*;;
    // ----------------------------------------
    // Clock, reset and counters
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1, rxd, txd, rts_n, cts_n, dwi = 1'b0, hwake, tv = 1'b0, trdy;
    logic rv, rrdy = 1'b0, ovr, bl = 1'b0, brej, fm = 1'b0, we = 1'b0, hreq = 1'b0, dw;
    logic [7:0] td = 8'h00;
    logic [15:0] bi = 16'h0000;
    hcu_rx_s rd;
    int n_errors = 0, cmp_count = 0, n_rej = 0, n_ovr = 0;
    logic [7:0] q[$];
    longint rt[4] = '{RATE_MIN_BPS, 230400, RATE_MID_BPS, RATE_MAX_BPS};
    always #20 clk = ~clk;
    always @(negedge clk) begin
        if (brej === 1'b1) n_rej++;
        if (ovr === 1'b1) n_ovr++;
    end
    hcu_uart #(.DEPTH(8), .RTS_LEVEL(4)) i_dut (
        .SYS_CLK(clk),
        .SYS_RST(rst),
        .UART_RXD(rxd),
        .UART_TXD(txd),
        .UART_RTS_N(rts_n),
        .UART_CTS_N(cts_n),
        .DEVICE_WAKE_IN(dwi),
        .HOST_WAKE(hwake),
        .TX_DATA(td),
        .TX_VALID(tv),
        .TX_READY(trdy),
        .RX_DATA(rd),
        .RX_VALID(rv),
        .RX_READY(rrdy),
        .RX_OVERRUN(ovr),
        .BAUD_INCR(bi),
        .BAUD_LOAD(bl),
        .BAUD_REJECT(brej),
        .FACTORY_MODE(fm),
        .WAKE_ENABLE(we),
        .HOST_WAKE_REQ(hreq),
        .DEVICE_WAKE(dw)
    );
    hcu_host_model i_host (.clk(clk), .rxd(rxd), .txd(txd), .rts_n(rts_n), .cts_n(cts_n));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] incr_of(input longint r);
        return 16'((r * 16 * 65536 + CLK_HZ / 2) / CLK_HZ);
    endfunction : incr_of
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task automatic tx_put(input logic [7:0] v);
        @(posedge clk) td <= v;
        tv <= 1'b1;
        do @(negedge clk); while (trdy !== 1'b1);
        @(posedge clk) tv <= 1'b0;
    endtask : tx_put
    task automatic rx_get(input logic [8:0] e);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rv !== 1'b1 && k < 4000);
        chk("rx_data", 16'(e), 16'(rd));
        @(posedge clk) rrdy <= 1'b1;
        @(posedge clk) rrdy <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : rx_get
    task automatic hx(input logic [7:0] e);
        int k;
        k = 0;
        while (i_host.got.size() == 0 && k < 30000) begin
            @(posedge clk);
            k++;
        end
        chk("host_rx", 16'({1'b0, e}), 16'(i_host.got.pop_front()));
    endtask : hx
    task automatic xchg(input logic [7:0] a, input logic [7:0] c);
        tx_put(a);
        i_host.send(c, 1'b1);
        hx(a);
        rx_get({1'b0, c});
    endtask : xchg
    task automatic baud(input logic [15:0] v);
        @(posedge clk) bi <= v;
        bl <= 1'b1;
        @(posedge clk) bl <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : baud
    task automatic txd_low();
        int k;
        k = 0;
        while (txd !== 1'b0 && k < 400) begin
            @(posedge clk);
            k++;
        end
    endtask : txd_low
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial begin
        int r0, k, idle;
        logic [7:0] b;
        void'($urandom(90));
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("txd_rst", 16'h1, 16'(txd));
        chk("rts_rst", 16'h1, 16'(rts_n));
        chk("wake_rst", 16'h0, 16'({hwake, dw}));
        @(posedge clk) rst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("rts_open", 16'h0, 16'(rts_n));
        chk("tx_ready", 16'h1, 16'(trdy));
        // Rejected loads must leave the default rate in place
        baud(16'h12DF);
        baud(16'hF5C4);
        chk("rejects", 16'h2, 16'(n_rej));
        xchg(8'($urandom), 8'($urandom));
        foreach (rt[i]) begin
            r0 = n_rej;
            baud(incr_of(rt[i]));
            i_host.bit_clks = int'((CLK_HZ + rt[i] / 2) / rt[i]);
            chk("reject", 16'(r0), 16'(n_rej));
            xchg(8'($urandom), 8'($urandom));
        end
        b = 8'($urandom);
        i_host.send(b, 1'b0);
        rx_get({1'b1, b});
        @(posedge clk) fm <= 1'b1;
        xchg(8'($urandom), 8'($urandom));
        r0 = i_host.n_sent;
        for (int i = 0; i < 6; i++) q.push_back(8'($urandom));
        fork
            foreach (q[i]) i_host.send(q[i], 1'b1);
        join_none
        repeat (2000) @(posedge clk);
        @(negedge clk);
        chk("rts_full", 16'h1, 16'(rts_n));
        chk("held_back", 16'(r0 + 4), 16'(i_host.n_sent));
        foreach (q[i]) rx_get({1'b0, q[i]});
        q.delete();
        i_host.ignore_rts = 1'b1;
        r0 = n_ovr;
        for (int i = 0; i < 10; i++) begin
            q.push_back(8'($urandom));
            i_host.send(q[i], 1'b1);
        end
        repeat (40) @(posedge clk);
        chk("overrun", 16'(r0 + 2), 16'(n_ovr));
        i_host.ignore_rts = 1'b0;
        for (int i = 0; i < 8; i++) rx_get({1'b0, q[i]});
        q.delete();
        @(posedge clk) i_host.cts_n <= 1'b1;
        repeat (5) @(posedge clk);
        td <= 8'($urandom);
        tv <= 1'b1;
        k = 0;
        idle = 0;
        while (idle < 4) begin
            @(negedge clk);
            if (trdy === 1'b1) begin
                q.push_back(td);
                k++;
                idle = 0;
                @(posedge clk) td <= 8'($urandom);
            end else begin
                idle++;
                @(posedge clk);
            end
        end
        tv <= 1'b0;
        chk("tx_depth", 16'h8, 16'(k));
        chk("cts_idle", 16'h1, 16'(txd));
        chk("cts_none", 16'h0, 16'(i_host.got.size()));
        @(posedge clk) i_host.cts_n <= 1'b0;
        foreach (q[i]) hx(q[i]);
        q.delete();
        b = 8'($urandom);
        tx_put(b);
        tx_put(~b);
        txd_low();
        @(posedge clk) i_host.cts_n <= 1'b1;
        repeat (600) @(posedge clk);
        chk("cts_mid", 16'h1, 16'(i_host.got.size()));
        @(posedge clk) i_host.cts_n <= 1'b0;
        hx(b);
        hx(~b);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) {we, fm, hreq, dwi} <= 4'(i);
            repeat (8) @(posedge clk);
            @(negedge clk);
            chk("wake", 16'({we & ~fm & hreq, we & ~fm & dwi}), 16'({hwake, dw}));
        end
        // Reset in mid-character must restore idle line and default rate
        tx_put(8'hA5);
        txd_low();
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("txd_rst2", 16'h1, 16'(txd));
        @(posedge clk) rst <= 1'b0;
        repeat (400) @(posedge clk);
        i_host.got.delete();
        i_host.bit_clks = 217;
        xchg(8'($urandom), 8'($urandom));
        conclude();
    end
endmodule : hcu_uart_tb_top
`default_nettype wire
